// ### design/bpfu_pkg.sv
// Constants and types shared by the bank/page fetch unit
// Operation
// [R01] Addresses are 24 bits: bank plus offset
// [R02] Fetch address is code bank plus pointer
// [R03] Pointer overflow increments the code bank
// [R04] Pointer borrow decrements the code bank
// [R05] Data bank plus computed offset for data
// [R06] Conventional direct: page zero base plus byte
// [R07] Mode select bit chooses direct scheme
// [R08] Mode select bit sticks until reset
// [R09] Expanded direct: four 64-byte windows
// [R10] Operand top two bits pick base register
// [R11] All core transfers pass through this unit
// [R12] Separate code, data and address buses
// [R13] Code bus fetches memory; peripherals data only
// [R14] Fetch address register tracks next byte
// [R15] Ten-byte prefetch queue
// [R16] Data address register holds next data address
// [R17] Thirty-two bit data buffer stages transfers
// [R18] Prefetch when bus free and queue has room
// [R19] Bytes handed to core only on request
// [R20] Branch flushes queue and refetches at target
// [R21] Fetch width follows fetch address alignment
// [R22] Core loads data address before transfer
// [R23] Bus cycle shaped by access size
// [R24] Fetch address advances, carrying into bank
package bpfu_pkg;
  localparam int          ADDR_W      = 24;
  localparam int          BANK_W      = 8;
  localparam int          OFS_W       = 16;
  localparam int          CODE_W      = 32;
  localparam int          DATA_W      = 16;
  localparam int          BUF_W       = 32;
  localparam int          QDEPTH      = 10;
  localparam int          QCNT_W      = 4;
  localparam int          PAGE_CNT    = 4;
  localparam int          BYTE_LANES  = 4;

  localparam logic [1:0]  SZ_BYTE     = 2'h0;
  localparam logic [1:0]  SZ_WORD     = 2'h1;
  localparam logic [1:0]  SZ_DWORD    = 2'h2;

  localparam logic [1:0]  AM_BANKED   = 2'h0;
  localparam logic [1:0]  AM_LONG     = 2'h1;
  localparam logic [1:0]  AM_DIRECT   = 2'h2;

  localparam logic [2:0]  SEL_DATA_BANK = 3'h0;
  localparam logic [2:0]  SEL_PAGE0     = 3'h1;
  localparam logic [2:0]  SEL_PAGE1     = 3'h2;
  localparam logic [2:0]  SEL_PAGE2     = 3'h3;
  localparam logic [2:0]  SEL_PAGE3     = 3'h4;
  localparam logic [2:0]  SEL_MODE1     = 3'h5;
  localparam int          MODE1_DIRECT_BIT = 1;

  localparam int          DP_SEL_LSB  = 6;
  localparam logic [7:0]  DIRECT_BANK = 8'h00;
  localparam logic [ADDR_W-1:0] STEP_ONE  = 24'h000001;
  localparam logic [ADDR_W-1:0] HALF_STEP = 24'h000002;
  localparam logic [QCNT_W-1:0] FOUR_B    = 4'h4;
  localparam logic [QCNT_W-1:0] TWO_B     = 4'h2;
  localparam logic [QCNT_W-1:0] ONE_B     = 4'h1;

  typedef enum logic [1:0] {
    BPFU_AL_ODD,
    BPFU_AL_EVEN,
    BPFU_AL_QUAD,
    BPFU_AL_OCT
  } bpfu_align_t;

  typedef enum logic [1:0] {
    BPFU_BUS_IDLE,
    BPFU_BUS_CODE,
    BPFU_BUS_DATA
  } bpfu_bus_st_t;
endpackage

// ### design/bpfu_q_if.sv
// Carrier between the fetch front end and the prefetch queue
`timescale 1ns/100ps
interface bpfu_q_if;
  import bpfu_pkg::*;
  logic                push_valid;
  logic [QCNT_W-1:0]   push_count;
  logic [CODE_W-1:0]   push_data;
  logic                pop;
  logic                flush;
  logic [7:0]          head;
  logic [QCNT_W-1:0]   count;

  modport fill (
    output push_valid, push_count, push_data, pop, flush,
    input  head, count
  );
  modport store (
    input  push_valid, push_count, push_data, pop, flush,
    output head, count
  );
endinterface

// ### design/bpfu_queue.sv
// Byte-wide prefetch queue, head at entry zero
`timescale 1ns/100ps
module bpfu_queue
  import bpfu_pkg::*;
#(
  parameter int DEPTH = QDEPTH
) (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  bpfu_q_if.store   q
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [QCNT_W-1:0]     count;
  } bpfu_queue_st_t;

  bpfu_queue_st_t r;
  bpfu_queue_st_t next_r;

  // ==========================================================
  // Pop, then append
  always_comb begin
    logic [QCNT_W-1:0] cnt;
    int                idx;
    next_r = r;
    cnt    = r.count;
    idx    = 0;
    // [R20] branch empties queue
    if (q.flush) begin
      next_r.count = '0;
    end else begin
      if (q.pop && r.count != '0) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          next_r.mem[i] = r.mem[i+1];
        end
        cnt = cnt - ONE_B;
      end
      // [R15] ten one-byte entries
      if (q.push_valid) begin
        for (int k = 0; k < BYTE_LANES; k++) begin
          idx = int'(cnt) + k;
          if (k < int'(q.push_count) && idx < DEPTH) begin
            next_r.mem[idx] = q.push_data[8*k +: 8];
          end
        end
        cnt = cnt + q.push_count;
      end
      next_r.count = cnt;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q.head  = r.mem[0];
  assign q.count = r.count;
endmodule

// ### design/bpfu_top.sv
// Bank/page address generation and fetch access unit front end
`timescale 1ns/100ps
module bpfu_top
  import bpfu_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // Branch / flush from the core
  input  wire logic              branch_i,
  input  wire logic              branch_rel_i,
  input  wire logic [BANK_W-1:0] branch_bank_i,
  input  wire logic [OFS_W-1:0]  branch_ofs_i,
  // Instruction byte hand-off
  input  wire logic              byte_req_i,
  output logic                   byte_valid_o,
  output logic [7:0]             byte_o,
  output logic [BANK_W-1:0]      code_bank_o,
  output logic [OFS_W-1:0]       fetch_pointer_o,
  // Core register writes
  input  wire logic              reg_we_i,
  input  wire logic [2:0]        reg_sel_i,
  input  wire logic [OFS_W-1:0]  reg_wdata_i,
  output logic                   direct_expanded_o,
  // Data access request
  input  wire logic              data_req_i,
  input  wire logic              data_we_i,
  input  wire logic [1:0]        data_size_i,
  input  wire logic [1:0]        data_mode_i,
  input  wire logic [BANK_W-1:0] data_bank_i,
  input  wire logic [OFS_W-1:0]  data_operand_i,
  input  wire logic [BUF_W-1:0]  data_wdata_i,
  output logic                   data_busy_o,
  output logic                   data_done_o,
  output logic [BUF_W-1:0]       data_rdata_o,
  // Internal buses
  output logic [ADDR_W-1:0]      abus_addr_o,
  output logic [1:0]             abus_size_o,
  output logic                   cbus_rd_o,
  input  wire logic [CODE_W-1:0] cbus_data_i,
  output logic                   dbus_rd_o,
  output logic                   dbus_wr_o,
  output logic [DATA_W-1:0]      dbus_wdata_o,
  input  wire logic [DATA_W-1:0] dbus_rdata_i,
  input  wire logic              bus_ack_i
);
  typedef struct packed {
    logic [BANK_W-1:0]                code_bank_reg;
    logic [OFS_W-1:0]                 next_fetch_pointer;
    logic [BANK_W-1:0]                data_bank_reg;
    logic [PAGE_CNT-1:0][OFS_W-1:0]   page_base;
    logic                             direct_expanded;
    logic [ADDR_W-1:0]                fetch_addr;
    logic [QCNT_W-1:0]                fetch_n;
    logic                             drop;
    bpfu_bus_st_t                     bus_st;
    logic [ADDR_W-1:0]                data_addr;
    logic [BUF_W-1:0]                 data_buf;
    logic                             data_we;
    logic [1:0]                       data_size;
    logic                             data_half;
    logic                             data_pend;
    logic                             data_done;
    logic                             byte_pend;
    logic                             byte_valid;
    logic [7:0]                       byte_data;
    logic [ADDR_W-1:0]                abus_addr;
    logic [1:0]                       abus_size;
    logic                             cbus_rd;
    logic                             dbus_rd;
    logic                             dbus_wr;
    logic [DATA_W-1:0]                dbus_wdata;
  } bpfu_st_t;

  bpfu_st_t r;
  bpfu_st_t next_r;

  bpfu_q_if qif ();

  bpfu_queue #(
    .DEPTH (QDEPTH)
  ) u_queue (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .q       (qif.store)
  );

  // ==========================================================
  // Address arithmetic
  logic [ADDR_W-1:0]  pc_full;
  logic [ADDR_W-1:0]  branch_dest;
  logic [OFS_W-1:0]   direct_ofs;
  logic [ADDR_W-1:0]  data_ea;
  logic [QCNT_W-1:0]  q_free;
  bpfu_align_t        fetch_align;
  logic [QCNT_W-1:0]  fetch_cnt;
  logic [1:0]         fetch_size;

  // [R02] code bank over pointer
  assign pc_full = {r.code_bank_reg, r.next_fetch_pointer};

  // [R03] [R04] relative carry or borrow moves bank
  assign branch_dest = branch_rel_i ?
                       pc_full + {{BANK_W{branch_ofs_i[OFS_W-1]}}, branch_ofs_i} :
                       {branch_bank_i, branch_ofs_i};

  always_comb begin
    // [R09] [R10] expanded: two select bits, six offset bits
    if (r.direct_expanded) begin
      direct_ofs = r.page_base[data_operand_i[7:DP_SEL_LSB]]
                 + {{(OFS_W-DP_SEL_LSB){1'b0}}, data_operand_i[DP_SEL_LSB-1:0]};
    // [R06] conventional: page zero base plus byte
    end else begin
      direct_ofs = r.page_base[0] + {{(OFS_W-8){1'b0}}, data_operand_i[7:0]};
    end
  end

  always_comb begin
    // [R01] [R05] bank plus in-bank offset
    unique case (data_mode_i)
      AM_LONG:   data_ea = {data_bank_i, data_operand_i};
      AM_DIRECT: data_ea = {DIRECT_BANK, direct_ofs};
      default:   data_ea = {r.data_bank_reg, data_operand_i};
    endcase
  end

  assign q_free = QCNT_W'(QDEPTH) - qif.count;

  always_comb begin
    // [R21] alignment class from low three bits
    if (r.fetch_addr[2:0] == 3'h0) begin
      fetch_align = BPFU_AL_OCT;
    end else if (r.fetch_addr[1:0] == 2'h0) begin
      fetch_align = BPFU_AL_QUAD;
    end else if (r.fetch_addr[0] == 1'b0) begin
      fetch_align = BPFU_AL_EVEN;
    end else begin
      fetch_align = BPFU_AL_ODD;
    end
  end

  always_comb begin
    // [R21] width limited by alignment and free room
    unique case (fetch_align)
      BPFU_AL_OCT, BPFU_AL_QUAD: begin
        if (q_free >= FOUR_B) begin
          fetch_cnt = FOUR_B;
        end else if (q_free >= TWO_B) begin
          fetch_cnt = TWO_B;
        end else begin
          fetch_cnt = ONE_B;
        end
      end
      BPFU_AL_EVEN: fetch_cnt = (q_free >= TWO_B) ? TWO_B : ONE_B;
      BPFU_AL_ODD:  fetch_cnt = ONE_B;
    endcase
    // [R23] bus size from byte count
    if (fetch_cnt == FOUR_B) begin
      fetch_size = SZ_DWORD;
    end else if (fetch_cnt == TWO_B) begin
      fetch_size = SZ_WORD;
    end else begin
      fetch_size = SZ_BYTE;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_r          = r;
    next_r.byte_valid = 1'b0;
    next_r.data_done  = 1'b0;
    qif.push_valid  = 1'b0;
    qif.push_count  = r.fetch_n;
    qif.push_data   = cbus_data_i;
    qif.pop         = 1'b0;
    qif.flush       = 1'b0;

    // Core register writes
    if (reg_we_i) begin
      unique case (reg_sel_i)
        SEL_DATA_BANK: next_r.data_bank_reg = reg_wdata_i[BANK_W-1:0];
        SEL_PAGE0:     next_r.page_base[0]  = reg_wdata_i;
        SEL_PAGE1:     next_r.page_base[1]  = reg_wdata_i;
        SEL_PAGE2:     next_r.page_base[2]  = reg_wdata_i;
        SEL_PAGE3:     next_r.page_base[3]  = reg_wdata_i;
        SEL_MODE1: begin
          // [R07] [R08] set only; reset alone clears
          if (reg_wdata_i[MODE1_DIRECT_BIT]) begin
            next_r.direct_expanded = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // [R19] hand a byte only against a request
    if (r.byte_pend && qif.count != '0 && !branch_i) begin
      qif.pop            = 1'b1;
      next_r.byte_valid  = 1'b1;
      next_r.byte_data   = qif.head;
      next_r.byte_pend   = 1'b0;
      // [R03] pointer overflow carries into bank
      {next_r.code_bank_reg, next_r.next_fetch_pointer} = pc_full + STEP_ONE;
    end
    if (byte_req_i) begin
      next_r.byte_pend = 1'b1;
    end

    // [R22] [R16] [R17] capture address and write data
    if (data_req_i && !r.data_pend) begin
      next_r.data_pend = 1'b1;
      next_r.data_addr = data_ea;
      next_r.data_we   = data_we_i;
      next_r.data_size = data_size_i;
      next_r.data_buf  = data_wdata_i;
      next_r.data_half = 1'b0;
    end

    // [R11] [R12] single owner of the internal buses
    unique case (r.bus_st)
      BPFU_BUS_IDLE: begin
        if (r.data_pend) begin
          // High half of a double word restarts here after its idle cycle
          next_r.bus_st     = BPFU_BUS_DATA;
          next_r.abus_addr  = r.data_half ? r.data_addr + HALF_STEP : r.data_addr;
          // [R23] double word runs as two word cycles
          next_r.abus_size  = (r.data_size == SZ_DWORD) ? SZ_WORD : r.data_size;
          next_r.dbus_rd    = !r.data_we;
          next_r.dbus_wr    = r.data_we;
          next_r.dbus_wdata = r.data_half ? r.data_buf[BUF_W-1:DATA_W]
                                          : r.data_buf[DATA_W-1:0];
        // [R18] [R13] fetch on code bus while room
        end else if (q_free != '0 && !branch_i) begin
          next_r.bus_st    = BPFU_BUS_CODE;
          next_r.abus_addr = r.fetch_addr;
          next_r.abus_size = fetch_size;
          next_r.fetch_n   = fetch_cnt;
          next_r.cbus_rd   = 1'b1;
          next_r.drop      = 1'b0;
        end
      end
      BPFU_BUS_CODE: begin
        if (bus_ack_i) begin
          next_r.bus_st  = BPFU_BUS_IDLE;
          next_r.cbus_rd = 1'b0;
          if (!r.drop && !branch_i) begin
            qif.push_valid    = 1'b1;
            // [R14] [R24] advance with carry into bank
            next_r.fetch_addr = r.fetch_addr + ADDR_W'(r.fetch_n);
          end
        end
      end
      BPFU_BUS_DATA: begin
        if (bus_ack_i) begin
          if (r.data_size == SZ_DWORD && !r.data_half) begin
            // Strobe drops for one idle cycle between the two halves
            next_r.data_half  = 1'b1;
            next_r.bus_st     = BPFU_BUS_IDLE;
            next_r.dbus_rd    = 1'b0;
            next_r.dbus_wr    = 1'b0;
            if (!r.data_we) begin
              next_r.data_buf[DATA_W-1:0] = dbus_rdata_i;
            end
          end else begin
            next_r.bus_st    = BPFU_BUS_IDLE;
            next_r.dbus_rd   = 1'b0;
            next_r.dbus_wr   = 1'b0;
            next_r.data_pend = 1'b0;
            next_r.data_done = 1'b1;
            if (!r.data_we) begin
              unique case (r.data_size)
                SZ_BYTE:  next_r.data_buf = {{(BUF_W-8){1'b0}}, dbus_rdata_i[7:0]};
                SZ_DWORD: next_r.data_buf[BUF_W-1:DATA_W] = dbus_rdata_i;
                default:  next_r.data_buf = {{(BUF_W-DATA_W){1'b0}}, dbus_rdata_i};
              endcase
            end
          end
        end
      end
      default: next_r.bus_st = BPFU_BUS_IDLE;
    endcase

    // [R20] flush queue, retarget fetch and pointer
    if (branch_i) begin
      qif.flush         = 1'b1;
      next_r.byte_pend  = byte_req_i;
      next_r.fetch_addr = branch_dest;
      {next_r.code_bank_reg, next_r.next_fetch_pointer} = branch_dest;
      if (r.bus_st == BPFU_BUS_CODE && !bus_ack_i) begin
        next_r.drop = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign byte_valid_o      = r.byte_valid;
  assign byte_o            = r.byte_data;
  assign code_bank_o       = r.code_bank_reg;
  assign fetch_pointer_o   = r.next_fetch_pointer;
  assign direct_expanded_o = r.direct_expanded;
  assign data_busy_o       = r.data_pend;
  assign data_done_o       = r.data_done;
  assign data_rdata_o      = r.data_buf;
  assign abus_addr_o       = r.abus_addr;
  assign abus_size_o       = r.abus_size;
  assign cbus_rd_o         = r.cbus_rd;
  assign dbus_rd_o         = r.dbus_rd;
  assign dbus_wr_o         = r.dbus_wr;
  assign dbus_wdata_o      = r.dbus_wdata;
endmodule

// ### tb/bpfu_props.sv
// Concurrent checks on the fetch unit top-level ports
`timescale 1ns/100ps
module bpfu_props
  import bpfu_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              reset_i,
  input wire logic              branch_i,
  input wire logic              branch_rel_i,
  input wire logic [BANK_W-1:0] branch_bank_i,
  input wire logic [OFS_W-1:0]  branch_ofs_i,
  input wire logic              byte_valid_o,
  input wire logic [BANK_W-1:0] code_bank_o,
  input wire logic [OFS_W-1:0]  fetch_pointer_o,
  input wire logic              reg_we_i,
  input wire logic [2:0]        reg_sel_i,
  input wire logic [OFS_W-1:0]  reg_wdata_i,
  input wire logic              direct_expanded_o,
  input wire logic              data_req_i,
  input wire logic              data_busy_o,
  input wire logic              data_done_o,
  input wire logic [ADDR_W-1:0] abus_addr_o,
  input wire logic [1:0]        abus_size_o,
  input wire logic              cbus_rd_o,
  input wire logic              dbus_rd_o,
  input wire logic              dbus_wr_o,
  input wire logic              bus_ack_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // ==========================================
  // Mode, branch and hand-off
  mode_set_a:
    assert property (reg_we_i && reg_sel_i == SEL_MODE1 && reg_wdata_i[1] |=> direct_expanded_o)
    else $error("mode bit not set by write");
  mode_sticky_a:
    assert property (direct_expanded_o |=> direct_expanded_o)
    else $error("mode bit cleared without reset");
  branch_abs_a:
    assert property (branch_i && !branch_rel_i |=>
      {code_bank_o, fetch_pointer_o} == {$past(branch_bank_i), $past(branch_ofs_i)})
    else $error("pointer not at branch target");
  branch_quiet_a:
    assert property (branch_i |=> !byte_valid_o [*2])
    else $error("stale byte handed out after branch");
  byte_step_a:
    assert property (byte_valid_o |->
      {code_bank_o, fetch_pointer_o} == {$past(code_bank_o), $past(fetch_pointer_o)} + 24'h000001)
    else $error("pointer did not step with carry");
  // ==========================================
  // Internal bus cycles
  fetch_hold_a:
    assert property (cbus_rd_o && !bus_ack_i |=>
      cbus_rd_o && $stable(abus_addr_o) && $stable(abus_size_o))
    else $error("fetch cycle changed before ack");
  data_hold_a:
    assert property ((dbus_rd_o || dbus_wr_o) && !bus_ack_i |=>
      $stable(dbus_rd_o) && $stable(dbus_wr_o) && $stable(abus_addr_o))
    else $error("data cycle changed before ack");
  bus_idle_a:
    assert property ((cbus_rd_o || dbus_rd_o || dbus_wr_o) && bus_ack_i |=>
      !(cbus_rd_o || dbus_rd_o || dbus_wr_o))
    else $error("no idle cycle after ack");
  one_owner_a:
    assert property (cbus_rd_o |-> !dbus_rd_o && !dbus_wr_o)
    else $error("code and data cycles overlap");
  fetch_align_a:
    assert property (cbus_rd_o |-> (abus_size_o == SZ_BYTE) ||
      (abus_size_o == SZ_WORD && !abus_addr_o[0]) ||
      (abus_size_o == SZ_DWORD && abus_addr_o[1:0] == 2'h0))
    else $error("fetch size does not suit alignment");
  done_ack_a:
    assert property (data_done_o |-> $past(bus_ack_i) ##1 !data_done_o)
    else $error("done without ack or too long");
  busy_cause_a:
    assert property ($rose(data_busy_o) |-> $past(data_req_i))
    else $error("busy without data request");
endmodule

bind bpfu_top bpfu_props u_props (
  .mclk_i(mclk_i), .reset_i(reset_i), .branch_i(branch_i), .branch_rel_i(branch_rel_i),
  .branch_bank_i(branch_bank_i), .branch_ofs_i(branch_ofs_i), .byte_valid_o(byte_valid_o),
  .code_bank_o(code_bank_o), .fetch_pointer_o(fetch_pointer_o), .reg_we_i(reg_we_i),
  .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i), .direct_expanded_o(direct_expanded_o),
  .data_req_i(data_req_i), .data_busy_o(data_busy_o), .data_done_o(data_done_o),
  .abus_addr_o(abus_addr_o), .abus_size_o(abus_size_o), .cbus_rd_o(cbus_rd_o),
  .dbus_rd_o(dbus_rd_o), .dbus_wr_o(dbus_wr_o), .bus_ack_i(bus_ack_i)
);

// ### tb/bpfu_mem_model.sv
// Memory and peripheral responder on the internal buses
`timescale 1ns/100ps
module bpfu_mem_model
  import bpfu_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic [3:0]        lat_i,
  input  wire logic              code_rd_i,
  input  wire logic              data_rd_i,
  input  wire logic              data_wr_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic [CODE_W-1:0]      code_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   ack_o
);
  logic [3:0] wait_cnt;
  logic       strobe;

  function automatic logic [7:0] cbyte(input logic [ADDR_W-1:0] a);
    return a[7:0] ^ a[23:16] ^ 8'h3C;
  endfunction

  assign strobe = code_rd_i | data_rd_i | data_wr_i;

  // ==========================================
  // Bus answers, idle lines toggle
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_cnt <= 4'h0;
      ack_o    <= 1'h0;
      code_o   <= 32'h00000000;
      rdata_o  <= 16'h0000;
    end else begin
      code_o  <= code_rd_i ? {cbyte(addr_i + 24'h3), cbyte(addr_i + 24'h2),
                              cbyte(addr_i + 24'h1), cbyte(addr_i)} : ~code_o;
      rdata_o <= data_rd_i ? (addr_i[15:0] ^ 16'h5A5A) : ~rdata_o;
      if (strobe && !ack_o && wait_cnt >= lat_i) begin
        ack_o    <= 1'h1;
        wait_cnt <= 4'h0;
      end else begin
        ack_o    <= 1'h0;
        wait_cnt <= (strobe && !ack_o) ? wait_cnt + 4'h1 : 4'h0;
      end
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the bank/page fetch unit
`timescale 1ns/100ps
module tb_top;
  import bpfu_pkg::*;
  typedef struct {
    logic        we;
    logic [1:0]  sz;
    logic [1:0]  md;
    logic [7:0]  bk;
    logic [15:0] op;
    logic [31:0] wd;
    logic [23:0] ea;
  } bpfu_row_t;

  logic              mclk_i, reset_i, branch_i, branch_rel_i, byte_req_i, byte_valid_o;
  logic              reg_we_i, direct_expanded_o, data_req_i, data_we_i, data_busy_o;
  logic              data_done_o, cbus_rd_o, dbus_rd_o, dbus_wr_o, bus_ack_i;
  logic [BANK_W-1:0] branch_bank_i, code_bank_o, data_bank_i;
  logic [OFS_W-1:0]  branch_ofs_i, fetch_pointer_o, reg_wdata_i, data_operand_i;
  logic [7:0]        byte_o;
  logic [2:0]        reg_sel_i;
  logic [1:0]        data_size_i, data_mode_i, abus_size_o;
  logic [31:0]       data_wdata_i, data_rdata_o, cbus_data_i;
  logic [23:0]       abus_addr_o;
  logic [15:0]       dbus_wdata_o, dbus_rdata_i;
  logic [3:0]        lat;
  int                n_fail, tests_run, fetched;
  bpfu_row_t         rows [9] = '{
    '{1'h0, SZ_WORD, AM_BANKED, 8'h00, 16'h3456, 32'h0, 24'h123456},
    '{1'h1, SZ_WORD, AM_LONG, 8'h77, 16'hFFFE, 32'h0000BEEF, 24'h77FFFE},
    '{1'h0, SZ_BYTE, AM_DIRECT, 8'h00, 16'hABC4, 32'h0, 24'h0010C4},
    '{1'h0, SZ_DWORD, AM_BANKED, 8'h00, 16'h2000, 32'h0, 24'h122000},
    '{1'h1, SZ_DWORD, AM_LONG, 8'h01, 16'h0010, 32'hCAFE1234, 24'h010010},
    '{1'h0, SZ_WORD, AM_DIRECT, 8'h00, 16'h00C6, 32'h0, 24'h0040C6},
    '{1'h1, SZ_WORD, AM_DIRECT, 8'h00, 16'h003E, 32'h0000A55A, 24'h00103E},
    '{1'h0, SZ_WORD, AM_DIRECT, 8'h00, 16'h007E, 32'h0, 24'h00207E},
    '{1'h0, SZ_BYTE, AM_DIRECT, 8'h00, 16'h0080, 32'h0, 24'h003080}};

  bpfu_top u_dut (.*);

  bpfu_mem_model u_mem (
    .mclk_i(mclk_i), .reset_i(reset_i), .lat_i(lat), .code_rd_i(cbus_rd_o),
    .data_rd_i(dbus_rd_o), .data_wr_i(dbus_wr_o), .addr_i(abus_addr_o),
    .code_o(cbus_data_i), .rdata_o(dbus_rdata_i), .ack_o(bus_ack_i));

  always #20 mclk_i = ~mclk_i;

  // Bytes taken from the code bus
  always @(posedge mclk_i) begin
    if (cbus_rd_o === 1'h1 && bus_ack_i === 1'h1) begin
      fetched <= fetched + (abus_size_o == SZ_DWORD ? 4 : (abus_size_o == SZ_WORD ? 2 : 1));
    end
  end

  // ==========================================
  // Tasks
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return byte_valid_o;
      1: return dbus_rd_o | dbus_wr_o;
      default: return data_done_o;
    endcase
  endfunction

  task automatic wait_for(input int s, input logic lvl);
    int i;
    for (i = 0; i < 80; i++) begin
      if (pick(s) === lvl) break;
      @(posedge mclk_i);
      #1;
    end
    if (i == 80) begin
      n_fail++;
      $display("timeout at %0t", $time);
      results();
    end
  endtask

  task automatic get_byte(input logic [23:0] a);
    @(posedge mclk_i);
    byte_req_i <= 1'h1;
    @(posedge mclk_i);
    byte_req_i <= 1'h0;
    #1;
    wait_for(0, 1'h1);
    check(byte_o, a[7:0] ^ a[23:16] ^ 8'h3C);
    check({code_bank_o, fetch_pointer_o}, a + 24'h1);
  endtask

  task automatic branch(input logic rel, input logic [23:0] t, input logic [23:0] exp);
    @(posedge mclk_i);
    {branch_i, branch_rel_i, branch_bank_i, branch_ofs_i} <= {1'h1, rel, t};
    @(posedge mclk_i);
    branch_i <= 1'h0;
    #1;
    check({code_bank_o, fetch_pointer_o}, exp);
  endtask

  task automatic wr_reg(input logic [2:0] s, input logic [15:0] d);
    @(posedge mclk_i);
    {reg_we_i, reg_sel_i, reg_wdata_i} <= {1'h1, s, d};
    @(posedge mclk_i);
    reg_we_i <= 1'h0;
  endtask

  task automatic data_op(input bpfu_row_t r);
    logic [23:0] a2;
    logic [15:0] lo, hi;
    @(posedge mclk_i);
    data_req_i <= 1'h1;
    {data_we_i, data_size_i, data_mode_i, data_bank_i, data_operand_i, data_wdata_i} <=
      {r.we, r.sz, r.md, r.bk, r.op, r.wd};
    @(posedge mclk_i);
    data_req_i <= 1'h0;
    #1;
    a2 = r.ea + 24'h000002;
    for (int k = 0; k < (r.sz == SZ_DWORD ? 2 : 1); k++) begin
      wait_for(1, 1'h1);
      check(abus_addr_o, k == 1 ? a2 : r.ea);
      check(abus_size_o, r.sz == SZ_DWORD ? SZ_WORD : r.sz);
      check(dbus_wr_o, r.we);
      if (r.we) check(dbus_wdata_o, r.wd[16*k +: 16]);
      wait_for(1, 1'h0);
    end
    wait_for(2, 1'h1);
    lo = r.ea[15:0] ^ 16'h5A5A;
    hi = a2[15:0] ^ 16'h5A5A;
    if (!r.we && r.sz == SZ_DWORD) check(data_rdata_o, {hi, lo});
    else if (!r.we && r.sz == SZ_BYTE) check(data_rdata_o, {24'h000000, lo[7:0]});
    else if (!r.we) check(data_rdata_o[15:0], lo);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {mclk_i, branch_i, branch_rel_i, byte_req_i, reg_we_i, data_req_i, data_we_i} = 7'h00;
    {branch_bank_i, branch_ofs_i, reg_sel_i, reg_wdata_i} = 43'h0;
    {data_size_i, data_mode_i, data_bank_i, data_operand_i, data_wdata_i} = 62'h0;
    {n_fail, tests_run, fetched} = {32'h0, 32'h0, 32'h0};
    reset_i = 1'h1;
    lat = 4'h0;
    repeat (20) @(posedge mclk_i);
    #1;
    check({code_bank_o, fetch_pointer_o, direct_expanded_o, byte_valid_o}, 32'h0);
    @(posedge mclk_i);
    reset_i <= 1'h0;
    repeat (60) @(posedge mclk_i);
    #1;
    check(fetched, 32'hA);
    check(cbus_rd_o, 1'h0);
    $display("test reset_fill done");
    lat = 4'h2;
    for (int i = 0; i < 12; i++) get_byte(24'(i));
    lat = 4'h5;
    branch(1'h0, 24'h05FFFD, 24'h05FFFD);
    for (int i = 0; i < 5; i++) get_byte(24'h05FFFD + 24'(i));
    branch(1'h1, 24'h00FFF0, 24'h05FFF2);
    get_byte(24'h05FFF2);
    $display("test branch done");
    wr_reg(SEL_DATA_BANK, 16'h0012);
    wr_reg(SEL_PAGE0, 16'h1000);
    wr_reg(SEL_PAGE1, 16'h2040);
    wr_reg(SEL_PAGE2, 16'h3080);
    wr_reg(SEL_PAGE3, 16'h40C0);
    for (int i = 0; i < 9; i++) begin
      lat = (i % 2 == 1) ? 4'h3 : 4'h0;
      if (i == 5) begin
        wr_reg(SEL_MODE1, 16'h0002);
        wr_reg(SEL_MODE1, 16'h0000);
        #1;
        check(direct_expanded_o, 1'h1);
      end
      data_op(rows[i]);
    end
    $display("test data done");
    @(posedge mclk_i);
    reset_i <= 1'h1;
    @(posedge mclk_i);
    reset_i <= 1'h0;
    #1;
    check({code_bank_o, fetch_pointer_o, direct_expanded_o}, 32'h0);
    get_byte(24'h000000);
    $display("test second reset done");
    results();
  end
endmodule
